// ==== verilog/pwm_timer_regs.vh ====
/*
 Register offsets, field positions and reset values of the PWM timer with capture.
 Assumes inclusion by the design files of this block only.
*/
`ifndef PWM_TIMER_REGS_VH
`define PWM_TIMER_REGS_VH

`define OFS_PRESCALE_DEADZONE 12'h000
`define OFS_CLOCK_SELECT      12'h004
`define OFS_TIMER_CONTROL     12'h008
`define OFS_PERIOD_RELOAD     12'h00c
`define OFS_COMPARE_0         12'h010
`define OFS_COUNTER_VALUE     12'h014
`define OFS_COMPARE_1         12'h01c
`define OFS_COMPARE_2         12'h028
`define OFS_COMPARE_3         12'h034
`define OFS_IRQ_ENABLE        12'h040
`define OFS_IRQ_FLAG          12'h044
`define OFS_CAPTURE_CONTROL   12'h050
`define OFS_RISE_LATCH        12'h058
`define OFS_FALL_LATCH        12'h05c
`define OFS_OUTPUT_CAPTURE_EN 12'h07c

`define RESET_WORD            32'h0000_0000

`define PSC_LSB               0
`define GAP0_LSB              16
`define GAP1_LSB              24

`define CTL_TIMER_RUN         0
`define CTL_OUTPUT_INVERT     2
`define CTL_RELOAD_MODE       3
`define CTL_GAP_GEN_0_ON      4
`define CTL_GAP_GEN_1_ON      5

`define CAP_INPUT_INVERT      0
`define CAP_RISE_IRQ_ON       1
`define CAP_FALL_IRQ_ON       2
`define CAP_ENABLE            3
`define CAP_IRQ_FLAG          4
`define CAP_RISE_LATCHED      6
`define CAP_FALL_LATCHED      7

`define PCEN_CAPTURE_IN       8

`endif

// ==== verilog/pwm_channel.v ====
/*
 One compare channel: holds a staged compare value and drives a raw level.
 Assumes the counter and PWM clock tick come from the timer core.
*/
`timescale 1ns/1ps
module pwm_channel
(
    // Clock and reset
    input  wire        clk_i,
    input  wire        reset_n_i,
    // Timer state
    input  wire        tick_i,
    input  wire        cycle_start_i,
    input  wire        running_i,
    input  wire [15:0] count_i,
    input  wire [15:0] period_i,
    input  wire [15:0] compare_i,
    // Output
    output reg         level_o
);
    reg [15:0] active_cmp;

    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            active_cmp <= 16'h0000;
            level_o    <= 1'b1;
        end
        else if (cycle_start_i)
        begin
            active_cmp <= compare_i;
            level_o    <= (compare_i >= period_i);
        end
        else if (tick_i && running_i)
        begin
            // Low while the count is above cmp, high from cmp down to zero
            if (active_cmp >= period_i)
                level_o <= 1'b1;
            else if (count_i == active_cmp + 16'h0001)
                level_o <= 1'b1;
            else if (count_i == 16'h0000)
                level_o <= 1'b0;
        end
    end
endmodule // pwm_channel

// ==== verilog/dead_zone.v ====
/*
 Dead-zone generator for one channel pair: delays each rising edge by a gap.
 Assumes tick_i is one PWM clock pulse in the system clock domain.
*/
`timescale 1ns/1ps
module dead_zone
(
    // Clock and reset
    input  wire       clk_i,
    input  wire       reset_n_i,
    // Control
    input  wire       enable_i,
    input  wire       tick_i,
    input  wire [7:0] gap_i,
    // Pair signals
    input  wire       level_a_i,
    input  wire       level_b_i,
    output wire       out_a_o,
    output wire       out_b_o
);
    reg [7:0] gap_count;
    reg       last_level;
    reg       gap_a;
    reg       gap_b;

    // Pair is complementary from channel a; b input only reaches out_b_o while disabled
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            gap_count  <= 8'h00;
            last_level <= 1'b0;
            gap_a      <= 1'b0;
            gap_b      <= 1'b0;
        end
        else if (tick_i)
        begin
            last_level <= level_a_i;
            if (level_a_i != last_level)
            begin
                gap_count <= gap_i;
                gap_a     <= 1'b0;
                gap_b     <= 1'b0;
            end
            else if (gap_count != 8'h00)
                gap_count <= gap_count - 8'h01;
            else
            begin
                gap_a <= level_a_i;
                gap_b <= ~level_a_i;
            end
        end
    end

    assign out_a_o = enable_i ? gap_a : level_a_i;
    assign out_b_o = enable_i ? gap_b : level_b_i;
endmodule // dead_zone

// ==== verilog/pwm_timer_with_capture.v ====
/*
 PWM timer with one 16-bit down-counter, four compare outputs, two dead-zone
 generators and one capture channel, reached over a plain register port.
 Assumes all inputs are synchronous to clk_i and software keeps its own order.
*/
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "pwm_timer_regs.vh"
module pwm_timer_with_capture
(
    // Clock and reset
    input  wire        clk_i,
    input  wire        reset_n_i,
    // Register port
    input  wire [11:0] addr_i,
    input  wire [31:0] wdata_i,
    input  wire        write_i,
    input  wire        read_i,
    output reg  [31:0] rdata_o,
    // Capture input pin
    input  wire        capture_pin_i,
    // PWM outputs and interrupt
    output wire [3:0]  pwm_o,
    output wire [3:0]  pwm_oe_n_o,
    output wire        irq_o
);
    // Registers
    reg  [31:0] prescale_deadzone;
    reg  [2:0]  clock_divide_select;
    reg  [5:0]  timer_control;
    reg  [15:0] period_reload;
    reg  [15:0] compare_0;
    reg  [15:0] compare_1;
    reg  [15:0] compare_2;
    reg  [15:0] compare_3;
    reg         timer_irq_on;
    reg         timer_irq_flag;
    reg  [7:0]  capture_control;
    reg  [15:0] rise_latch_value;
    reg  [15:0] fall_latch_value;
    reg  [8:0]  output_capture_enable;
    // Timer state
    reg  [15:0] live_count;
    reg         counting;
    reg         run_seen;
    reg  [7:0]  psc_count;
    reg         psc_tick;
    reg  [3:0]  div_count;
    reg         cap_last;
    wire [7:0]  prescale_value;
    wire [7:0]  gap_length_0;
    wire [7:0]  gap_length_1;
    wire        timer_run;
    wire        output_invert;
    wire        reload_mode;
    wire        gap_gen_0_on;
    wire        gap_gen_1_on;
    reg         pwm_tick;
    wire        cycle_start;
    wire        cap_level;
    wire        cap_rise;
    wire        cap_fall;
    wire        cap_irq_event;
    wire        cap_reload;
    wire        zero_event;
    wire [3:0]  raw_level;
    wire [3:0]  shaped;
    wire [15:0] compare_bank [0:3];
    reg         next_counting;
    reg  [15:0] next_count;

    assign prescale_value = prescale_deadzone[`PSC_LSB+7:`PSC_LSB];
    assign gap_length_0   = prescale_deadzone[`GAP0_LSB+7:`GAP0_LSB];
    assign gap_length_1   = prescale_deadzone[`GAP1_LSB+7:`GAP1_LSB];
    assign timer_run      = timer_control[`CTL_TIMER_RUN];
    assign output_invert  = timer_control[`CTL_OUTPUT_INVERT];
    assign reload_mode    = timer_control[`CTL_RELOAD_MODE];
    assign gap_gen_0_on   = timer_control[`CTL_GAP_GEN_0_ON];
    assign gap_gen_1_on   = timer_control[`CTL_GAP_GEN_1_ON];

    // Prescaler: one tick every value+1 clocks, none when value is zero
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            psc_count <= 8'h00;
            psc_tick  <= 1'b0;
        end
        else if (prescale_value == 8'h00)
        begin
            psc_count <= 8'h00;
            psc_tick  <= 1'b0;
        end
        else if (psc_count >= prescale_value)
        begin
            psc_count <= 8'h00;
            psc_tick  <= 1'b1;
        end
        else
        begin
            psc_count <= psc_count + 8'h01;
            psc_tick  <= 1'b0;
        end
    end

    // Clock selector works on prescaler ticks
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            div_count <= 4'h0;
        else if (psc_tick)
            div_count <= div_count + 4'h1;
    end

    always @*
    begin
        case (clock_divide_select)
            3'h0:    pwm_tick = psc_tick && (div_count[0] == 1'b1);
            3'h1:    pwm_tick = psc_tick && (div_count[1:0] == 2'h3);
            3'h2:    pwm_tick = psc_tick && (div_count[2:0] == 3'h7);
            3'h3:    pwm_tick = psc_tick && (div_count == 4'hf);
            default: pwm_tick = psc_tick;
        endcase
    end

    // Capture edge detection; input taken as synchronous
    assign cap_level   = capture_pin_i ^ capture_control[`CAP_INPUT_INVERT];
    assign cap_rise    = capture_control[`CAP_ENABLE] && output_capture_enable[`PCEN_CAPTURE_IN]
                         && cap_level && !cap_last;
    assign cap_fall    = capture_control[`CAP_ENABLE] && output_capture_enable[`PCEN_CAPTURE_IN]
                         && !cap_level && cap_last;
    assign cap_irq_event = (cap_rise && capture_control[`CAP_RISE_IRQ_ON])
                         || (cap_fall && capture_control[`CAP_FALL_IRQ_ON]);
    // A pending capture flag suppresses reloads on capture events
    assign cap_reload  = cap_irq_event && !capture_control[`CAP_IRQ_FLAG];

    assign zero_event  = pwm_tick && counting && timer_run && (live_count == 16'h0000);
    assign cycle_start = (zero_event && reload_mode && (period_reload != 16'h0000))
                         || cap_reload || (timer_run && !run_seen);

    // Down-counter
    always @*
    begin
        next_counting = counting;
        next_count    = live_count;
        if (!timer_run)
            next_counting = 1'b0;
        else if (cap_reload)
        begin
            next_count    = period_reload;
            next_counting = 1'b1;
        end
        else if (!run_seen)
        begin
            next_count    = period_reload;
            next_counting = (period_reload != 16'h0000);
        end
        else if (counting && pwm_tick)
        begin
            if (live_count != 16'h0000)
                next_count = live_count - 16'h0001;
            else if (reload_mode && period_reload != 16'h0000)
                next_count = period_reload;
            else
                next_counting = 1'b0;
        end
    end

    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            live_count <= 16'h0000;
            counting   <= 1'b0;
            run_seen   <= 1'b0;
            cap_last   <= 1'b0;
        end
        else
        begin
            live_count <= next_count;
            counting   <= next_counting && timer_run;
            run_seen   <= timer_run;
            cap_last   <= cap_level;
        end
    end

    // Register writes, with hardware sets winning over software clears
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            prescale_deadzone     <= `RESET_WORD;
            clock_divide_select   <= 3'h0;
            timer_control         <= 6'h00;
            period_reload         <= 16'h0000;
            compare_0             <= 16'h0000;
            compare_1             <= 16'h0000;
            compare_2             <= 16'h0000;
            compare_3             <= 16'h0000;
            timer_irq_on          <= 1'b0;
            timer_irq_flag        <= 1'b0;
            capture_control       <= 8'h00;
            rise_latch_value      <= 16'h0000;
            fall_latch_value      <= 16'h0000;
            output_capture_enable <= 9'h000;
        end
        else
        begin
            if (write_i)
            begin
                case (addr_i)
                    `OFS_PRESCALE_DEADZONE: prescale_deadzone <= {wdata_i[31:16], 8'h00,
                                                                  wdata_i[7:0]};
                    `OFS_CLOCK_SELECT:      clock_divide_select <= wdata_i[2:0];
                    `OFS_TIMER_CONTROL:     timer_control <= {wdata_i[5:2], 1'b0, wdata_i[0]};
                    `OFS_PERIOD_RELOAD:     period_reload <= wdata_i[15:0];
                    `OFS_COMPARE_0:         compare_0 <= wdata_i[15:0];
                    `OFS_COMPARE_1:         compare_1 <= wdata_i[15:0];
                    `OFS_COMPARE_2:         compare_2 <= wdata_i[15:0];
                    `OFS_COMPARE_3:         compare_3 <= wdata_i[15:0];
                    `OFS_IRQ_ENABLE:        timer_irq_on <= wdata_i[0];
                    `OFS_IRQ_FLAG:
                        if (wdata_i[0])
                            timer_irq_flag <= 1'b0;
                    `OFS_CAPTURE_CONTROL:
                    begin
                        capture_control[3:0] <= wdata_i[3:0];
                        if (wdata_i[`CAP_IRQ_FLAG])
                            capture_control[`CAP_IRQ_FLAG] <= 1'b0;
                        if (!wdata_i[`CAP_RISE_LATCHED])
                            capture_control[`CAP_RISE_LATCHED] <= 1'b0;
                        if (!wdata_i[`CAP_FALL_LATCHED])
                            capture_control[`CAP_FALL_LATCHED] <= 1'b0;
                    end
                    `OFS_OUTPUT_CAPTURE_EN: output_capture_enable <= {wdata_i[8], 4'h0,
                                                                      wdata_i[3:0]};
                    default: ;
                endcase
            end
            if (zero_event)
                timer_irq_flag <= 1'b1;
            if (cap_rise)
            begin
                rise_latch_value <= live_count;
                capture_control[`CAP_RISE_LATCHED] <= 1'b1;
            end
            if (cap_fall)
            begin
                fall_latch_value <= live_count;
                capture_control[`CAP_FALL_LATCHED] <= 1'b1;
            end
            if (cap_irq_event)
                capture_control[`CAP_IRQ_FLAG] <= 1'b1;
        end
    end

    // Read data in the cycle after the strobe
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rdata_o <= `RESET_WORD;
        else if (read_i)
        begin
            case (addr_i)
                `OFS_PRESCALE_DEADZONE: rdata_o <= prescale_deadzone;
                `OFS_CLOCK_SELECT:      rdata_o <= {29'h0, clock_divide_select};
                `OFS_TIMER_CONTROL:     rdata_o <= {26'h0, timer_control};
                `OFS_PERIOD_RELOAD:     rdata_o <= {16'h0, period_reload};
                `OFS_COMPARE_0:         rdata_o <= {16'h0, compare_0};
                `OFS_COUNTER_VALUE:     rdata_o <= {16'h0, live_count};
                `OFS_COMPARE_1:         rdata_o <= {16'h0, compare_1};
                `OFS_COMPARE_2:         rdata_o <= {16'h0, compare_2};
                `OFS_COMPARE_3:         rdata_o <= {16'h0, compare_3};
                `OFS_IRQ_ENABLE:        rdata_o <= {31'h0, timer_irq_on};
                `OFS_IRQ_FLAG:          rdata_o <= {31'h0, timer_irq_flag};
                `OFS_CAPTURE_CONTROL:   rdata_o <= {24'h0, capture_control};
                `OFS_RISE_LATCH:        rdata_o <= {16'h0, rise_latch_value};
                `OFS_FALL_LATCH:        rdata_o <= {16'h0, fall_latch_value};
                `OFS_OUTPUT_CAPTURE_EN: rdata_o <= {23'h0, output_capture_enable};
                default:                rdata_o <= `RESET_WORD;
            endcase
        end
        else
            rdata_o <= `RESET_WORD;
    end

    // Timer and capture share the single interrupt line
    assign irq_o = (timer_irq_on && timer_irq_flag)
                 || capture_control[`CAP_IRQ_FLAG];

    assign compare_bank[0] = compare_0;
    assign compare_bank[1] = compare_1;
    assign compare_bank[2] = compare_2;
    assign compare_bank[3] = compare_3;

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1)
        begin : g_chan
            pwm_channel u_chan
            (
                .clk_i         (clk_i),
                .reset_n_i     (reset_n_i),
                .tick_i        (pwm_tick),
                .cycle_start_i (cycle_start),
                .running_i     (counting),
                .count_i       (live_count),
                .period_i      (period_reload),
                .compare_i     (compare_bank[ch]),
                .level_o       (raw_level[ch])
            );
        end
    endgenerate

    dead_zone u_gap_0
    (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .enable_i  (gap_gen_0_on),
        .tick_i    (pwm_tick),
        .gap_i     (gap_length_0),
        .level_a_i (raw_level[0]),
        .level_b_i (raw_level[1]),
        .out_a_o   (shaped[0]),
        .out_b_o   (shaped[1])
    );

    dead_zone u_gap_1
    (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .enable_i  (gap_gen_1_on),
        .tick_i    (pwm_tick),
        .gap_i     (gap_length_1),
        .level_a_i (raw_level[2]),
        .level_b_i (raw_level[3]),
        .out_a_o   (shaped[2]),
        .out_b_o   (shaped[3])
    );

    assign pwm_o      = shaped ^ {4{output_invert}};
    assign pwm_oe_n_o = ~output_capture_enable[3:0];
endmodule // pwm_timer_with_capture

// ==== bench/pwm_timer_with_capture_assertions.sv ====
/*
 Port checker for the PWM timer with capture.
 Assumes a bind from the testbench top file and register writes on the plain port.
*/
`timescale 1ns/1ps
module pwm_timer_with_capture_assertions
(
    // Clock, reset, register port
    input wire        clk_i,
    input wire        reset_n_i,
    input wire [11:0] addr_i,
    input wire [31:0] wdata_i,
    input wire        write_i,
    input wire        read_i,
    input wire [31:0] rdata_o,
    // Pins
    input wire        capture_pin_i,
    input wire [3:0]  pwm_o,
    input wire [3:0]  pwm_oe_n_o,
    input wire        irq_o
);
    reg [7:0] psc;
    reg [5:0] ctl;
    reg       irq_on;
    reg       cap_ever;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Shadows; capture stays sticky since its flag may outlive the enable
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            psc      <= 8'h00;
            ctl      <= 6'h00;
            irq_on   <= 1'b0;
            cap_ever <= 1'b0;
        end
        else if (write_i)
        begin
            if (addr_i == 12'h000)
                psc <= wdata_i[7:0];
            if (addr_i == 12'h008)
                ctl <= wdata_i[5:0];
            if (addr_i == 12'h040)
                irq_on <= wdata_i[0];
            if (addr_i == 12'h050 && wdata_i[3])
                cap_ever <= 1'b1;
        end
    end
    sequence period_wr;
        write_i && addr_i == 12'h00c;
    endsequence
    sequence period_rd;
        read_i && addr_i == 12'h00c;
    endsequence
    rdata_idle_a: assert property (!read_i |=> rdata_o == 32'h0)
        else $error("read data not idle");
    period_readback_a: assert property (period_wr ##2 period_rd |=>
        rdata_o == {16'h0, $past(wdata_i[15:0], 3)}) else $error("period read back wrong");
    select_field_a: assert property (read_i && addr_i == 12'h004 |=>
        rdata_o[31:3] == 29'h0) else $error("select reserved bits set");
    prescale_hold_a: assert property (psc == 8'h00 && !cap_ever && !write_i
        && !$past(write_i) |=> $stable(pwm_o)) else $error("outputs move with prescale zero");
    invert_flip_a: assert property (write_i && addr_i == 12'h008 && !ctl[0]
        && (wdata_i[5:0] ^ ctl) == 6'h04 |=> pwm_o == ~$past(pwm_o)) else $error("no invert");
    reset_level_a: assert property ($rose(reset_n_i) |-> pwm_o == 4'hf
        && pwm_oe_n_o == 4'hf && !irq_o) else $error("bad level after reset");
    irq_gate_a: assert property (!irq_on && !cap_ever |-> !irq_o)
        else $error("interrupt while disabled");
    flag_clear_a: assert property (write_i && addr_i == 12'h044 && wdata_i[0]
        && !ctl[0] && !cap_ever |=> !irq_o) else $error("flag not cleared");
endmodule // pwm_timer_with_capture_assertions

// ==== bench/pwm_load_model.sv ====
/*
 Far side: a load timing channel 0 pulses and the source of the capture pin.
 Assumes set_level is called from the bench's main sequence.
*/
`timescale 1ns/1ps
module pwm_load_model
(
    // Clock and reset
    input  wire        clk_i,
    input  wire        reset_n_i,
    // Device pins
    input  wire [3:0]  pwm_i,
    input  wire [3:0]  pwm_oe_n_i,
    output reg         capture_pin_o,
    // Last whole phase widths in clocks
    output reg  [15:0] high_len_o,
    output reg  [15:0] low_len_o
);
    reg        last;
    reg [15:0] run;
    initial capture_pin_o = 1'b0;
    // Source moves just after an edge, as a synchronous driver would
    task set_level(input logic lvl);
        @(posedge clk_i);
        capture_pin_o <= lvl;
    endtask
    // Undriven pin is ignored so widths only count real drive
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            last       <= 1'b1;
            run        <= 16'h0;
            high_len_o <= 16'h0;
            low_len_o  <= 16'h0;
        end
        else if (!pwm_oe_n_i[0])
        begin
            last <= pwm_i[0];
            run  <= (pwm_i[0] == last) ? run + 16'h1 : 16'h1;
            if (pwm_i[0] != last && last)
                high_len_o <= run;
            if (pwm_i[0] != last && !last)
                low_len_o <= run;
        end
    end
endmodule // pwm_load_model

// ==== bench/pwm_timer_with_capture_tb.sv ====
/*
 Self-checking bench for the PWM timer with capture.
 Assumes design, load model and checker are compiled before this file.
*/
`timescale 1ns/1ps
module pwm_timer_with_capture_tb;
    reg          clk_i = 1'b0;
    reg          reset_n_i = 1'b0;
    reg  [11:0]  addr_i = 12'h0;
    reg  [31:0]  wdata_i = 32'h0;
    reg          write_i = 1'b0;
    reg          read_i = 1'b0;
    wire [31:0]  rdata_o;
    wire         cap_pin;
    wire [3:0]   pwm_o;
    wire [3:0]   pwm_oe_n_o;
    wire         irq_o;
    wire [15:0]  high_len;
    wire [15:0]  low_len;
    integer      mismatches = 0;
    integer      check_count = 0;
    integer      cycles = 0;
    integer      i;
    integer      k;
    logic [31:0] d;
    logic [31:0] e;
    logic [11:0] ra [11] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h01c,
                             12'h028, 12'h034, 12'h07c, 12'h014, 12'h018};
    logic [31:0] rw [11] = '{32'h1234_5603, 32'hffff_fffd, 32'hffff_fffe, 32'habcd_0009,
                             32'hffff_8001, 32'h1_0002, 32'h2_0003, 32'h3_0004,
                             32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff};
    logic [31:0] re [11] = '{32'h1234_0003, 32'h5, 32'h3c, 32'h9, 32'h8001, 32'h2,
                             32'h3, 32'h4, 32'h10f, 32'h0, 32'h0};
    pwm_timer_with_capture u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
        .capture_pin_i(cap_pin), .pwm_o(pwm_o), .pwm_oe_n_o(pwm_oe_n_o), .irq_o(irq_o));
    pwm_load_model u_load (.clk_i(clk_i), .reset_n_i(reset_n_i), .pwm_i(pwm_o),
        .pwm_oe_n_i(pwm_oe_n_o), .capture_pin_o(cap_pin), .high_len_o(high_len),
        .low_len_o(low_len));
    initial
    begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= v;
        write_i <= 1'b1;
        @(posedge clk_i);
        write_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        read_i <= 1'b1;
        @(posedge clk_i);
        read_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        check_count = check_count + 1;
        if (got !== exp)
            $display("MISMATCH t=%0t exp %h got %h", $time, exp, got);
        if (got !== exp)
            mismatches = mismatches + 1;
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Whole run is near 1300 cycles; the ceiling leaves ample margin
    always @(posedge clk_i)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            mismatches = mismatches + 1;
            wrap_up;
        end
    end
    initial
    begin
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        #1;
        chk({pwm_oe_n_o, pwm_o, 3'h0, irq_o}, 12'hff0);
        for (i = 0; i < 11; i = i + 1)
        begin
            rd(ra[i], d);
            chk(32'h0, d);
            wr(ra[i], rw[i]);
            rd(ra[i], d);
            chk(re[i], d);
        end
        $display("registers done");
        wr(12'h008, 32'h0);
        wr(12'h008, 32'h4);
        chk(pwm_o, 4'h0);
        wr(12'h008, 32'h0);
        wr(12'h000, 32'h1);
        wr(12'h00c, 32'h1);
        wr(12'h010, 32'h0);
        for (k = 0; k < 5; k = k + 1)
        begin
            wr(12'h004, k);
            wr(12'h008, 32'h9);
            repeat (24 << k) @(posedge clk_i);
            chk(high_len, (k == 4) ? 2 : 4 << k);
            chk(low_len, (k == 4) ? 2 : 4 << k);
            wr(12'h008, 32'h0);
        end
        $display("divider done");
        wr(12'h010, 32'h3);
        wr(12'h00c, 32'h9);
        wr(12'h008, 32'h9);
        repeat (80) @(posedge clk_i);
        chk({high_len, low_len}, {16'd8, 16'd12});
        wr(12'h010, 32'h5);
        repeat (80) @(posedge clk_i);
        chk({high_len, low_len}, {16'd12, 16'd8});
        wr(12'h010, 32'h9);
        repeat (40) @(posedge clk_i);
        for (i = 0; i < 20; i = i + 1)
        begin
            @(posedge clk_i);
            chk(pwm_o[0], 1'b1);
        end
        wr(12'h000, 32'h0);
        rd(12'h014, d);
        repeat (20) @(posedge clk_i);
        rd(12'h014, e);
        chk(d, e);
        wr(12'h000, 32'h1);
        $display("duty done");
        wr(12'h008, 32'h0);
        wr(12'h044, 32'h1);
        wr(12'h040, 32'h1);
        wr(12'h008, 32'h1);
        for (i = 0; i < 100 && irq_o !== 1'b1; i = i + 1)
            @(posedge clk_i);
        chk(irq_o, 1'b1);
        rd(12'h014, d);
        repeat (20) @(posedge clk_i);
        rd(12'h014, e);
        chk(d, e);
        wr(12'h040, 32'h0);
        chk(irq_o, 1'b0);
        wr(12'h040, 32'h1);
        chk(irq_o, 1'b1);
        wr(12'h008, 32'h0);
        wr(12'h044, 32'h1);
        chk(irq_o, 1'b0);
        wr(12'h040, 32'h0);
        $display("one-shot done");
        wr(12'h00c, 32'hff);
        wr(12'h050, 32'he);
        wr(12'h008, 32'h9);
        repeat (60) @(posedge clk_i);
        rd(12'h014, d);
        u_load.set_level(1'b1);
        repeat (6) @(posedge clk_i);
        chk(irq_o, 1'b1);
        rd(12'h058, e);
        chk(e <= d && e + 8 >= d, 1'b1);
        rd(12'h014, d);
        chk(d <= 32'hff && d >= 32'hf0, 1'b1);
        wr(12'h050, 32'h1a);
        u_load.set_level(1'b0);
        repeat (6) @(posedge clk_i);
        chk(irq_o, 1'b0);
        rd(12'h05c, e);
        chk(e != 0 && e <= 32'hff, 1'b1);
        $display("capture done");
        wrap_up;
    end
endmodule // pwm_timer_with_capture_tb
bind pwm_timer_with_capture pwm_timer_with_capture_assertions u_chk (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i),
    .read_i(read_i), .rdata_o(rdata_o), .capture_pin_i(capture_pin_i), .pwm_o(pwm_o),
    .pwm_oe_n_o(pwm_oe_n_o), .irq_o(irq_o));
